// >>> ccsr_host_model.sv
// two-wire bus controller model driving clock and pulling data low
module ccsr_host_model
    import ccsr_pkg::*;
(
    input logic ref_clk_i,
    input logic sda_wire_i,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // quarter bit, changes just after a clock edge
    task automatic q;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : q
    // data moves only with the clock line low
    task automatic put_bit(input logic b);
        sda_low_o = !b;
        q();
        scl_o = 1'b1;
        q();
        q();
        scl_o = 1'b0;
        q();
    endtask : put_bit
    // released line floats high unless the device holds it
    task automatic get_bit(output logic b);
        sda_low_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        b = sda_wire_i;
        q();
        scl_o = 1'b0;
        q();
    endtask : get_bit
    task automatic start;
        sda_low_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_low_o = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask : start
    task automatic byte_out(input logic [7:0] d, output logic n);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(n);
    endtask : byte_out
    // pointer write, then a data byte or a repeated start and a nacked one-byte read
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd, output logic [7:0] r);
        logic n;
        start();
        byte_out({I2C_DEV_ADDR, 1'b0}, n);
        byte_out(a, n);
        if (rd) begin
            start();
            byte_out({I2C_DEV_ADDR, 1'b1}, n);
            for (int i = 7; i >= 0; i--) get_bit(r[i]);
            put_bit(1'b1);
        end else begin
            byte_out(d, n);
        end
        sda_low_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_low_o = 1'b0;
        q();
    endtask : xfer
endmodule : ccsr_host_model

// >>> ccsr_pkg.sv
// constants, types and register layout for the converter control and status registers
// Operation
// - forced_high_impedance set holds high-impedance state, overriding enable pin and enable_override.
// - forced_high_impedance clear lets the device enter output_on_state under enable conditions.
// - accepted watchdog_kick write restarts the watchdog timer; bit self-clears to 0.
// - min_switch_freq_floor set keeps switching frequency at or above 31.25kHz.
// - defaults_restore write of 1 returns every register to default; reads back 0.
// - shutdown after 8 or 16 consecutive current limit cycles unless disabled.
// - switch_peak_current_limit selects 8.5A when 0 and 10A when 1.
// - aux_regulator_on switches auxiliary regulator off at 0, on at 1; default 1.
// - watchdog_period: 00 disabled, 01 80s, 10 160s, 11 320s.
// - disabled watchdog setting clears the timer count to zero.
// - irq_pin_level shows 0 when pin driven low, 1 when released.
// - enable_pin_level shows present enable pin level.
// - system_state reports 00 high-impedance, 10 output_on_state; 11 never used.
// - thermal_regulating reads 1 while thermal regulation is active.
// - watchdog expiry while enabled sets the latched watchdog_expiry_flag.
// - host read of watchdog register, or disabling, clears the watchdog timer.
package ccsr_pkg;
    // register offsets
    localparam logic [7:0] REG_CTRL_ONE = 8'h00;
    localparam logic [7:0] REG_CTRL_TWO = 8'h01;
    localparam logic [7:0] REG_GEN_STATUS = 8'h02;
    localparam logic [7:0] REG_THERM_STATUS = 8'h03;
    localparam logic [7:0] REG_RESERVED = 8'h04;
    // main_control_one fields
    localparam int CTRL1_HIZ_BIT = 7;
    localparam int CTRL1_KICK_BIT = 2;
    localparam int CTRL1_FLOOR_BIT = 1;
    localparam int CTRL1_RESTORE_BIT = 0;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    // main_control_two fields
    localparam int CTRL2_OCP_DIS_BIT = 6;
    localparam int CTRL2_ILIM_BIT = 4;
    localparam int CTRL2_AUX_BIT = 2;
    localparam int CTRL2_WDP_LSB = 0;
    localparam logic [7:0] CTRL2_RESET = 8'hB4;
    localparam logic [7:0] CTRL2_RSVD_MASK = 8'hA8;
    // status fields
    localparam int STAT_IRQ_BIT = 6;
    localparam int STAT_EN_BIT = 5;
    localparam int STAT_SYS_LSB = 0;
    localparam int THERM_ACTIVE_BIT = 6;
    localparam logic [1:0] SYS_CODE_HIZ = 2'h0;
    localparam logic [1:0] SYS_CODE_ON = 2'h2;
    // serial port
    localparam logic [6:0] I2C_DEV_ADDR = 7'h24;
    localparam logic [3:0] I2C_BITS_PER_BYTE = 4'h8;
    // watchdog periods
    localparam logic [1:0] WDP_OFF = 2'h0;
    localparam logic [1:0] WDP_80S = 2'h1;
    localparam logic [1:0] WDP_160S = 2'h2;
    localparam int WDP_W = 2;
    localparam int WD_CNT_W = 36;
    localparam longint unsigned CLK_HZ = 64'd100_000_000;
    localparam longint unsigned WD_BASE_S = 64'd80;
    localparam longint unsigned WD_BASE_CYC = WD_BASE_S * CLK_HZ;
    // overcurrent shutdown run lengths
    localparam logic [4:0] OCP_RUN_SHORT = 5'h08;
    localparam logic [4:0] OCP_RUN_LONG = 5'h10;
    // frequency floor: 31.25kHz is a 32000ns period, rounded down to cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLOOR_PERIOD_NS = 32000;
    localparam logic [11:0] FLOOR_CYC = 12'(FLOOR_PERIOD_NS / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
        I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK
    } ccsr_i2c_state_t;

    typedef enum logic {
        SYS_HIZ, SYS_ON
    } ccsr_sys_state_t;
endpackage : ccsr_pkg

// >>> ccsr_top.sv
// converter control and status register bank behind a two-wire serial slave port
module ccsr_top
    import ccsr_pkg::*;
#(
    parameter longint unsigned WD_BASE_CYCLES = WD_BASE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial port pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // enable conditions
    input wire logic en_pin_i,
    input wire logic enable_override_i,
    // converter feedback
    input wire logic sw_cycle_i,
    input wire logic ilim_trip_i,
    input wire logic ocp_long_run_i,
    input wire logic thermal_reg_i,
    input wire logic irq_assert_i,
    // interrupt_request_pin, open drain
    output logic irq_pin_o,
    output logic irq_pin_oe_n_o,
    // converter controls
    output logic output_on_o,
    output logic ilim_high_o,
    output logic aux_regulator_on_o,
    output logic freq_floor_en_o,
    output logic force_cycle_o,
    output logic ocp_shutdown_o,
    output logic watchdog_expiry_o
);
    // serial slave state
    ccsr_i2c_state_t i2c_ff;
    logic scl_q_ff;
    logic sda_q_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] ptr_ff;
    logic rw_ff;
    logic sda_oe_n_ff;
    logic drive_low_ff;

    // control fields
    logic hiz_ff;
    logic floor_ff;
    logic ocp_dis_ff;
    logic ilim_ff;
    logic aux_ff;
    logic [WDP_W-1:0] wdp_ff;
    logic kick_ff;
    logic wd_read_ff;
    logic wd_flag_ff;

    // status and converter side
    ccsr_sys_state_t sys_ff;
    logic en_lvl_ff;
    logic therm_ff;
    logic irq_oe_n_ff;
    logic [4:0] ocp_cnt_ff;
    logic ocp_latched_ff;
    logic [11:0] floor_cnt_ff;
    logic force_ff;

    // decoded events
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic byte_done;
    logic wr_commit;
    logic rd_load;
    logic restore;
    logic [7:0] rd_data;
    logic [4:0] ocp_run;

    ccsr_wd_if wd_if ();

    // byte returned for a register pointer; unmapped and reserved read zero
    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            REG_CTRL_ONE: begin
                v[CTRL1_HIZ_BIT] = hiz_ff;
                v[CTRL1_FLOOR_BIT] = floor_ff; // kick and restore always read 0
            end
            REG_CTRL_TWO: begin
                v = CTRL2_RESET & CTRL2_RSVD_MASK;
                v[CTRL2_OCP_DIS_BIT] = ocp_dis_ff;
                v[CTRL2_ILIM_BIT] = ilim_ff;
                v[CTRL2_AUX_BIT] = aux_ff;
                v[CTRL2_WDP_LSB +: WDP_W] = wdp_ff;
            end
            REG_GEN_STATUS: begin
                v[STAT_IRQ_BIT] = irq_oe_n_ff;
                v[STAT_EN_BIT] = en_lvl_ff;
                v[STAT_SYS_LSB +: 2] = (sys_ff == SYS_ON) ? SYS_CODE_ON : SYS_CODE_HIZ;
            end
            REG_THERM_STATUS: begin
                v[THERM_ACTIVE_BIT] = therm_ff;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    // pins are synchronous; one stage of history gives the edges
    assign scl_rise = scl_i & ~scl_q_ff;
    assign scl_fall = ~scl_i & scl_q_ff;
    assign start_cond = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
    assign stop_cond = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
    assign byte_done = scl_fall && (bit_cnt_ff == I2C_BITS_PER_BYTE);

    // a write lands on the falling edge after its eighth bit
    assign wr_commit = (i2c_ff == I2C_WDATA) && byte_done && !start_cond && !stop_cond;
    assign rd_load = scl_fall && !start_cond && !stop_cond &&
        (((i2c_ff == I2C_ADDR_ACK) && rw_ff) || (i2c_ff == I2C_RACK));
    assign rd_data = reg_read(ptr_ff);
    assign restore = wr_commit && (ptr_ff == REG_CTRL_ONE) && shift_ff[CTRL1_RESTORE_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_i;
            sda_q_ff <= sda_i;
        end
    end

    // serial slave: address, pointer, then data bytes with auto-increment
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            i2c_ff <= I2C_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else if (start_cond) begin
            i2c_ff <= I2C_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe_n_ff <= 1'b1;
        end else if (stop_cond) begin
            i2c_ff <= I2C_IDLE;
            sda_oe_n_ff <= 1'b1;
        end else begin
            case (i2c_ff)
                I2C_ADDR, I2C_PTR, I2C_WDATA: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_i};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_ff <= 4'h0;
                        sda_oe_n_ff <= 1'b0; // acknowledge by pulling low
                        if (i2c_ff == I2C_ADDR) begin
                            if (shift_ff[7:1] == I2C_DEV_ADDR) begin
                                rw_ff <= shift_ff[0];
                                i2c_ff <= I2C_ADDR_ACK;
                            end else begin
                                sda_oe_n_ff <= 1'b1; // not ours, stay off the bus
                                i2c_ff <= I2C_IDLE;
                            end
                        end else if (i2c_ff == I2C_PTR) begin
                            ptr_ff <= shift_ff;
                            i2c_ff <= I2C_PTR_ACK;
                        end else begin
                            ptr_ff <= ptr_ff + 8'h01;
                            i2c_ff <= I2C_WACK;
                        end
                    end
                end
                I2C_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            sda_oe_n_ff <= rd_data[7];
                            shift_ff <= {rd_data[6:0], 1'b0};
                            ptr_ff <= ptr_ff + 8'h01;
                            i2c_ff <= I2C_RDATA;
                        end else begin
                            sda_oe_n_ff <= 1'b1;
                            i2c_ff <= I2C_PTR;
                        end
                    end
                end
                I2C_PTR_ACK, I2C_WACK: begin
                    if (scl_fall) begin
                        sda_oe_n_ff <= 1'b1;
                        i2c_ff <= I2C_WDATA;
                    end
                end
                I2C_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_ff <= 4'h0;
                        sda_oe_n_ff <= 1'b1; // release for the host acknowledge
                        i2c_ff <= I2C_RACK;
                    end else if (scl_fall) begin
                        sda_oe_n_ff <= shift_ff[7];
                        shift_ff <= {shift_ff[6:0], 1'b0};
                    end
                end
                I2C_RACK: begin
                    if (scl_rise && sda_i) begin
                        i2c_ff <= I2C_IDLE; // not acknowledged: host ends the read
                    end else if (scl_fall) begin
                        sda_oe_n_ff <= rd_data[7];
                        shift_ff <= {rd_data[6:0], 1'b0};
                        ptr_ff <= ptr_ff + 8'h01;
                        i2c_ff <= I2C_RDATA;
                    end
                end
                default: begin
                    sda_oe_n_ff <= 1'b1;
                    bit_cnt_ff <= 4'h0;
                end
            endcase
        end
    end

    // the low level on both open-drain pins never changes; only the enables move
    always_ff @(posedge ref_clk_i) begin
        drive_low_ff <= 1'b0;
    end

    // control register writes; restore wins over any field in the same byte
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || restore) begin
            hiz_ff <= CTRL1_RESET[CTRL1_HIZ_BIT];
            floor_ff <= CTRL1_RESET[CTRL1_FLOOR_BIT];
            ocp_dis_ff <= CTRL2_RESET[CTRL2_OCP_DIS_BIT];
            ilim_ff <= CTRL2_RESET[CTRL2_ILIM_BIT];
            aux_ff <= CTRL2_RESET[CTRL2_AUX_BIT];
            wdp_ff <= CTRL2_RESET[CTRL2_WDP_LSB +: WDP_W];
        end else if (wr_commit && ptr_ff == REG_CTRL_ONE) begin
            hiz_ff <= shift_ff[CTRL1_HIZ_BIT];
            floor_ff <= shift_ff[CTRL1_FLOOR_BIT];
        end else if (wr_commit && ptr_ff == REG_CTRL_TWO) begin
            ocp_dis_ff <= shift_ff[CTRL2_OCP_DIS_BIT];
            ilim_ff <= shift_ff[CTRL2_ILIM_BIT];
            aux_ff <= shift_ff[CTRL2_AUX_BIT];
            wdp_ff <= shift_ff[CTRL2_WDP_LSB +: WDP_W];
        end
        // status and reserved offsets store nothing
    end

    // kick and watchdog-read are one-cycle strobes; the kick bit never holds a 1
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            kick_ff <= 1'b0;
            wd_read_ff <= 1'b0;
        end else begin
            kick_ff <= wr_commit && (ptr_ff == REG_CTRL_ONE) && shift_ff[CTRL1_KICK_BIT];
            wd_read_ff <= rd_load && (ptr_ff == REG_CTRL_TWO);
        end
    end

    assign wd_if.period = wdp_ff;
    assign wd_if.kick = kick_ff;
    assign wd_if.read_clr = wd_read_ff;

    ccsr_watchdog #(
        .WD_BASE_CYCLES(WD_BASE_CYCLES)
    ) u_watchdog (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wd(wd_if.timer)
    );

    // expiry flag is latched; an expiry in the restore cycle still sets it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wd_flag_ff <= 1'b0;
        end else if (wd_if.expired) begin
            wd_flag_ff <= 1'b1;
        end else if (restore) begin
            wd_flag_ff <= 1'b0;
        end
    end

    // sampled pin and converter levels for the status bytes
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            en_lvl_ff <= 1'b0;
            therm_ff <= 1'b0;
            irq_oe_n_ff <= 1'b1;
        end else begin
            en_lvl_ff <= en_pin_i;
            therm_ff <= thermal_reg_i;
            irq_oe_n_ff <= ~irq_assert_i;
        end
    end

    // top-level state: forced high impedance beats every enable source
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sys_ff <= SYS_HIZ;
        end else begin
            case (sys_ff)
                SYS_HIZ: begin
                    if (!hiz_ff && (en_pin_i || enable_override_i) && !ocp_latched_ff) begin
                        sys_ff <= SYS_ON;
                    end
                end
                SYS_ON: begin
                    if (hiz_ff || !(en_pin_i || enable_override_i) || ocp_latched_ff) begin
                        sys_ff <= SYS_HIZ;
                    end
                end
                default: sys_ff <= SYS_HIZ;
            endcase
        end
    end

    // consecutive limit cycles; the latch holds the converter off until restore or disable
    assign ocp_run = ocp_long_run_i ? OCP_RUN_LONG : OCP_RUN_SHORT;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || restore) begin
            ocp_cnt_ff <= 5'h00;
            ocp_latched_ff <= 1'b0;
        end else begin
            if (sw_cycle_i) begin
                if (!ilim_trip_i) begin
                    ocp_cnt_ff <= 5'h00;
                end else if (ocp_cnt_ff < ocp_run) begin
                    ocp_cnt_ff <= ocp_cnt_ff + 5'h01;
                end
            end
            if (ocp_dis_ff) begin
                ocp_latched_ff <= 1'b0;
            end else if (sw_cycle_i && ilim_trip_i && (ocp_cnt_ff + 5'h01 >= ocp_run)) begin
                ocp_latched_ff <= 1'b1;
            end
        end
    end

    // frequency floor: fill in a cycle when the converter goes quiet too long
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !floor_ff || sw_cycle_i) begin
            floor_cnt_ff <= 12'h000;
            force_ff <= 1'b0;
        end else if (floor_cnt_ff >= FLOOR_CYC - 12'h001) begin
            floor_cnt_ff <= 12'h000;
            force_ff <= 1'b1;
        end else begin
            floor_cnt_ff <= floor_cnt_ff + 12'h001;
            force_ff <= 1'b0;
        end
    end

    assign sda_o = drive_low_ff;
    assign sda_oe_n_o = sda_oe_n_ff;
    assign irq_pin_o = drive_low_ff;
    assign irq_pin_oe_n_o = irq_oe_n_ff;
    assign output_on_o = (sys_ff == SYS_ON);
    assign ilim_high_o = ilim_ff;
    assign aux_regulator_on_o = aux_ff;
    assign freq_floor_en_o = floor_ff;
    assign force_cycle_o = force_ff;
    assign ocp_shutdown_o = ocp_latched_ff;
    assign watchdog_expiry_o = wd_flag_ff;
endmodule : ccsr_top

// >>> ccsr_top_asserts.sv
// port-level checks for the converter register bank
module ccsr_top_asserts
    import ccsr_pkg::*;
#(
    parameter longint unsigned WD_BASE_CYCLES = WD_BASE_CYC
) (
    input logic ref_clk_i,
    input logic rst_i,
    input logic sda_o,
    input logic en_pin_i,
    input logic enable_override_i,
    input logic sw_cycle_i,
    input logic ilim_trip_i,
    input logic ocp_long_run_i,
    input logic irq_assert_i,
    input logic irq_pin_o,
    input logic irq_pin_oe_n_o,
    input logic output_on_o,
    input logic ilim_high_o,
    input logic aux_regulator_on_o,
    input logic freq_floor_en_o,
    input logic force_cycle_o,
    input logic ocp_shutdown_o,
    input logic watchdog_expiry_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] run_ff;
    logic [15:0] gap_ff;
    logic [39:0] up_ff;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // tripped cycles in a row; saturating, so it cannot wrap
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            run_ff <= 5'h00;
        end else if (sw_cycle_i) begin
            run_ff <= ilim_trip_i ? run_ff + 5'(run_ff != 5'h1F) : 5'h00;
        end
    end
    // clocks since the last cycle, floor on
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !freq_floor_en_o || sw_cycle_i || force_cycle_o) begin
            gap_ff <= 16'h0000;
        end else begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end
    // clocks since reset; no expiry before one base period
    always_ff @(posedge ref_clk_i) begin
        up_ff <= rst_i ? 40'h00_0000_0000 : up_ff + 40'h00_0000_0001;
    end
    chk_irq_level_follow: assert property (!rst_i |=> irq_pin_oe_n_o == !$past(irq_assert_i))
        else $error("irq enable not following request");
    chk_open_drain_zero: assert property (!sda_o && !irq_pin_o)
        else $error("open-drain pin driven high");
    chk_reset_values: assert property ($fell(rst_i) |-> ilim_high_o && aux_regulator_on_o && !output_on_o
        && !ocp_shutdown_o && !watchdog_expiry_o && !freq_floor_en_o)
        else $error("outputs wrong after reset");
    chk_off_without_enable: assert property (!(en_pin_i || enable_override_i) [*4] |-> !output_on_o)
        else $error("output on without enable");
    chk_ocp_holds_hiz: assert property (ocp_shutdown_o [*3] |-> !output_on_o)
        else $error("output on after shutdown");
    chk_ocp_run_length: assert property ($rose(ocp_shutdown_o) |-> run_ff >= (ocp_long_run_i ? 5'h10 : 5'h08))
        else $error("shutdown before full trip run");
    chk_floor_gap_bound: assert property (gap_ff <= 3205)
        else $error("switching gap beyond floor");
    chk_floor_single_pulse: assert property (force_cycle_o |-> $past(freq_floor_en_o) ##1 !force_cycle_o)
        else $error("bad forced cycle pulse");
    chk_wdog_not_early: assert property ($rose(watchdog_expiry_o) |-> up_ff >= WD_BASE_CYCLES)
        else $error("watchdog expiry too early");
    cover property ($rose(ocp_shutdown_o));
    cover property ($rose(watchdog_expiry_o));
    cover property (force_cycle_o);
endmodule : ccsr_top_asserts

bind ccsr_top ccsr_top_asserts #(.WD_BASE_CYCLES(WD_BASE_CYCLES)) u_ccsr_top_asserts (.*);

// >>> ccsr_watchdog.sv
// host watchdog timer with selectable period
module ccsr_watchdog
    import ccsr_pkg::*;
#(
    parameter longint unsigned WD_BASE_CYCLES = WD_BASE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    ccsr_wd_if.timer wd
);
    logic [WD_CNT_W-1:0] cnt_ff;
    logic expired_ff;

    // timeout length in cycles for a period code
    function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [WDP_W-1:0] code);
        logic [WD_CNT_W-1:0] base;
        base = WD_CNT_W'(WD_BASE_CYCLES);
        case (code)
            WDP_80S: wd_limit = base;
            WDP_160S: wd_limit = base << 1;
            default: wd_limit = base << 2;
        endcase
    endfunction : wd_limit

    assign wd.expired = expired_ff;

    // count up while enabled; a kick, a read or disabling starts again from zero
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
            expired_ff <= 1'b0;
        end else if (wd.period == WDP_OFF) begin
            cnt_ff <= '0;
            expired_ff <= 1'b0;
        end else if (wd.kick || wd.read_clr) begin
            cnt_ff <= '0;
            expired_ff <= 1'b0;
        end else if (cnt_ff >= wd_limit(wd.period) - 1'b1) begin
            cnt_ff <= '0;
            expired_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            expired_ff <= 1'b0;
        end
    end
endmodule : ccsr_watchdog

// >>> ccsr_wd_if.sv
// link between the register bank and its watchdog timer
interface ccsr_wd_if;
    import ccsr_pkg::*;
    logic [WDP_W-1:0] period;
    logic kick;
    logic read_clr;
    logic expired;
    modport ctrl (output period, output kick, output read_clr, input expired);
    modport timer (input period, input kick, input read_clr, output expired);
endinterface : ccsr_wd_if

// >>> tb_ccsr_top.sv
// self-checking bench for the converter register bank
module tb_ccsr_top
    import ccsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam longint unsigned WDB = 2000;
    logic ref_clk_i = 0, rst_i = 1, scl_i, sda_i, sda_o, sda_oe_n_o, sda_low;
    logic en_pin_i = 0, enable_override_i = 0, sw_cycle_i = 0, ilim_trip_i = 0, ocp_long_run_i = 0;
    logic thermal_reg_i = 0, irq_assert_i = 0, irq_pin_o, irq_pin_oe_n_o, output_on_o, ilim_high_o;
    logic aux_regulator_on_o, freq_floor_en_o, force_cycle_o, ocp_shutdown_o, watchdog_expiry_o;
    int bad_count = 0, comparisons = 0, n;
    always #5 ref_clk_i = !ref_clk_i;
    // pulled-up data line level
    assign sda_i = !sda_low && (sda_oe_n_o || sda_o);
    ccsr_top #(.WD_BASE_CYCLES(WDB)) u_ccsr_top (.*);
    ccsr_host_model u_host (.ref_clk_i(ref_clk_i), .sda_wire_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low));
    task automatic test_done;
        $display("checks %0d bad %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask : cyc
    task automatic bound(input int lim);
        cyc(1);
        n++;
        if (n >= lim) begin
            bad_count++;
            test_done();
        end
    endtask : bound
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer(a, d, 1'b0, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        u_host.xfer(a, 8'h00, 1'b1, r);
        chk(r, exp);
    endtask : rd
    // one switching cycle
    task automatic pulse(input logic trip);
        ilim_trip_i = trip;
        sw_cycle_i = 1'b1;
        cyc(1);
        sw_cycle_i = 1'b0;
        cyc(3);
    endtask : pulse
    initial begin
        cyc(2);
        rst_i = 1'b0;
        cyc(2);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'hB4);
        rd(8'h04, 8'h00);
        chk(ilim_high_o, 1'b1);
        $display("defaults done");
        // reserved bits kept at defaults
        wr(8'h01, 8'hE0);
        rd(8'h01, 8'hE0);
        chk(ilim_high_o, 1'b0);
        chk(aux_regulator_on_o, 1'b0);
        en_pin_i = 1'b1;
        thermal_reg_i = 1'b1;
        cyc(5);
        chk(output_on_o, 1'b1);
        rd(8'h02, 8'h62);
        rd(8'h03, 8'h40);
        irq_assert_i = 1'b1;
        thermal_reg_i = 1'b0;
        enable_override_i = 1'b1;
        rd(8'h02, 8'h22);
        rd(8'h03, 8'h00);
        $display("status done");
        // forced high impedance beats both enables
        wr(8'h00, 8'h80);
        chk(output_on_o, 1'b0);
        rd(8'h02, 8'h20);
        en_pin_i = 1'b0;
        wr(8'h00, 8'h00);
        chk(output_on_o, 1'b1);
        wr(8'h02, 8'hFF);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'h00);
        rd(8'h00, 8'h00);
        $display("override done");
        wr(8'h00, 8'h06);
        rd(8'h00, 8'h02);
        chk(freq_floor_en_o, 1'b1);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (force_cycle_o !== 1'b1) bound(4000);
            cyc(1);
        end
        chk(8'(n >= 3190 && n <= 3205), 8'h01);
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'hB4);
        $display("floor done");
        // a clean cycle restarts the run; then the exact run trips
        for (int m = 0; m < 2; m++) begin
            ocp_long_run_i = m[0];
            repeat (5) pulse(1'b1);
            pulse(1'b0);
            repeat (m ? 15 : 7) pulse(1'b1);
            chk(ocp_shutdown_o, 1'b0);
            pulse(1'b1);
            chk(ocp_shutdown_o, 1'b1);
            chk(output_on_o, 1'b0);
            wr(8'h00, 8'h01);
            chk(ocp_shutdown_o, 1'b0);
        end
        wr(8'h01, 8'hF4);
        repeat (20) pulse(1'b1);
        chk(ocp_shutdown_o, 1'b0);
        $display("shutdown done");
        wr(8'h01, 8'hB5);
        repeat (4) wr(8'h00, 8'h04);
        repeat (8) rd(8'h01, 8'hB5);
        cyc(1500);
        wr(8'h01, 8'hB4);
        chk(watchdog_expiry_o, 1'b0);
        // each period, timed from the write selecting it
        for (int p = 1; p < 4; p++) begin
            wr(8'h01, 8'hB4 | 8'(p));
            n = 0;
            while (watchdog_expiry_o !== 1'b1) bound(9000);
            chk(8'(n + 30 >= (WDB << (p - 1)) && n <= (WDB << (p - 1)) + 5), 8'h01);
            wr(8'h00, 8'h01);
            chk(watchdog_expiry_o, 1'b0);
        end
        $display("watchdog done");
        test_done();
    end
endmodule : tb_ccsr_top
